// ===== design/cfc_flow_ctrl.v
/*
 * Conditional flow control: decides jumps, subroutine entries and exits,
 * their delayed forms, and conditional execution of following words.
 * Assumes the decoder presents one instruction per i_issue pulse with its
 * word count, and that status inputs come from core logic on i_mclk,
 * except the branch input pin, which is asynchronous.
 */
// How it works
// - A conditional exit is one word yet costs the same cycles as a conditional jump.
// - A combined test passes only when every selected condition holds.
// - Up to four conditions may be combined, at most one from each group.
// - The groups are sum sign and zero, wrap flag, carry, and test flag or input pin.
// - Delayed transfers run two one-word or one two-word slot instruction in two cycles.
// - A two-word instruction right after a delayed transfer fills the whole slot.
// - A delayed transfer's condition is captured before its slot instructions run.
// - Conditional execute governs one word, or two words in its long form.
// - Conditional execute uses the same condition codes as jumps, entries and exits.
// - A failed conditional execute turns the governed words into no-operations.
// - Conditional execute tests status as it stood one full cycle earlier.
// - Status from a two-cycle instruction before it is settled in time to be tested.
// - An interrupt between the previous instruction and conditional execute lets its status count.
// - Group one compares the sum against zero six ways.
// - A plain conditional jump takes four cycles when taken and two when not.
// - A taken conditional entry pushes the address after it onto the stack.
`timescale 1ns/100ps
`include "cfc_defines.vh"

module cfc_flow_ctrl #(
    parameter ACC_W = 32,
    parameter PC_W = 16
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_issue,
    input wire [`CFC_OP_W-1:0] i_op,
    input wire i_delayed,
    input wire [`CFC_COND_W-1:0] i_cond,
    input wire [PC_W-1:0] i_target,
    input wire [PC_W-1:0] i_next_pc,
    input wire i_word_two,
    input wire i_word_valid,
    input wire i_after_irq,
    input wire [ACC_W-1:0] i_sum,
    input wire i_wrap,
    input wire i_carry,
    input wire i_test,
    input wire i_pin,
    input wire [PC_W-1:0] i_stack_top,
    output reg o_busy,
    output reg o_load_pc,
    output reg [PC_W-1:0] o_new_pc,
    output reg o_flush,
    output reg o_push,
    output reg [PC_W-1:0] o_push_pc,
    output reg o_pop,
    output reg o_squash,
    output reg o_cond_err
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_SLOT = 2'h2;
    localparam ST_EXEC = 2'h3;

    reg pin_s1_r;
    reg pin_s2_r;
    reg [ACC_W-1:0] sum_d_r;
    reg wrap_d_r;
    reg carry_d_r;
    reg test_d_r;
    reg pin_d_r;
    reg [1:0] st_r;
    reg [2:0] cnt_r;
    reg [1:0] words_r;
    reg pass_r;
    reg [`CFC_OP_W-1:0] op_r;
    reg [PC_W-1:0] dest_r;
    reg [PC_W-1:0] ret_r;

    wire now_true;
    wire now_bad;
    wire old_true;
    wire old_bad;
    wire is_xfer;
    wire is_exec;
    wire exec_true;
    wire [PC_W-1:0] dest_sel;
    wire [31:0] taken_wait;

    // Branch input pin is asynchronous
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= i_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Status delayed one cycle for conditional execute
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sum_d_r <= {ACC_W{1'b0}};
            wrap_d_r <= 1'b0;
            carry_d_r <= 1'b0;
            test_d_r <= 1'b0;
            pin_d_r <= 1'b1;
        end else begin
            sum_d_r <= i_sum;
            wrap_d_r <= i_wrap;
            carry_d_r <= i_carry;
            test_d_r <= i_test;
            pin_d_r <= pin_s2_r;
        end
    end

    cfc_cond_eval #(
        .ACC_W(ACC_W)
    ) u_now (
        .i_cond(i_cond),
        .i_sum(i_sum),
        .i_wrap(i_wrap),
        .i_carry(i_carry),
        .i_test(i_test),
        .i_pin_sync(pin_s2_r),
        .o_true(now_true),
        .o_bad(now_bad)
    );

    cfc_cond_eval #(
        .ACC_W(ACC_W)
    ) u_old (
        .i_cond(i_cond),
        .i_sum(sum_d_r),
        .i_wrap(wrap_d_r),
        .i_carry(carry_d_r),
        .i_test(test_d_r),
        .i_pin_sync(pin_d_r),
        .o_true(old_true),
        .o_bad(old_bad)
    );

    assign is_xfer = (i_op == `CFC_OP_JUMP) || (i_op == `CFC_OP_ENTRY) ||
                     (i_op == `CFC_OP_EXIT);
    assign is_exec = (i_op == `CFC_OP_EXEC1) || (i_op == `CFC_OP_EXEC2);
    // After an interrupt the previous status has settled, so use it live
    assign exec_true = i_after_irq ? now_true : old_true;
    assign dest_sel = (i_op == `CFC_OP_EXIT) ? i_stack_top : i_target;
    // Load on the third edge after issue, so the next issue is four cycles on
    assign taken_wait = `CFC_TAKEN_CYC - 1;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= 3'h0;
            words_r <= 2'h0;
            pass_r <= 1'b0;
            op_r <= `CFC_OP_NONE;
            dest_r <= {PC_W{1'b0}};
            ret_r <= {PC_W{1'b0}};
            o_busy <= 1'b0;
            o_load_pc <= 1'b0;
            o_new_pc <= {PC_W{1'b0}};
            o_flush <= 1'b0;
            o_push <= 1'b0;
            o_push_pc <= {PC_W{1'b0}};
            o_pop <= 1'b0;
            o_squash <= 1'b0;
            o_cond_err <= 1'b0;
        end else begin
            o_load_pc <= 1'b0;
            o_flush <= 1'b0;
            o_push <= 1'b0;
            o_pop <= 1'b0;
            o_squash <= 1'b0;
            o_cond_err <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (i_issue && (is_xfer || is_exec)) begin
                        op_r <= i_op;
                        dest_r <= dest_sel;
                        ret_r <= i_next_pc;
                        o_busy <= 1'b1;
                        if (is_exec) begin
                            o_cond_err <= old_bad;
                            pass_r <= exec_true && !old_bad;
                            words_r <= (i_op == `CFC_OP_EXEC2) ? `CFC_SLOT_WORDS : 2'h1;
                            st_r <= ST_EXEC;
                        end else begin
                            o_cond_err <= now_bad;
                            // Condition captured now; slot words cannot alter it
                            pass_r <= now_true && !now_bad;
                            words_r <= `CFC_SLOT_WORDS;
                            // Exit costs as a jump despite one word
                            cnt_r <= i_delayed ? 3'h1 : taken_wait[2:0];
                            st_r <= i_delayed ? ST_SLOT : ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!pass_r) begin
                        // Untaken: next instruction already fetched
                        o_busy <= 1'b0;
                        st_r <= ST_IDLE;
                    end else if (cnt_r == 3'h1) begin
                        o_load_pc <= 1'b1;
                        o_new_pc <= dest_r;
                        o_flush <= 1'b1;
                        o_push <= (op_r == `CFC_OP_ENTRY);
                        o_push_pc <= ret_r;
                        o_pop <= (op_r == `CFC_OP_EXIT);
                        o_busy <= 1'b0;
                        st_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                ST_SLOT: begin
                    // Slot instructions run while target is fetched
                    if (i_word_valid) begin
                        if (i_word_two || words_r == 2'h1) begin
                            o_load_pc <= pass_r;
                            o_new_pc <= dest_r;
                            o_push <= pass_r && (op_r == `CFC_OP_ENTRY);
                            o_push_pc <= ret_r;
                            o_pop <= pass_r && (op_r == `CFC_OP_EXIT);
                            o_busy <= 1'b0;
                            st_r <= ST_IDLE;
                        end else begin
                            words_r <= words_r - 2'h1;
                        end
                    end
                end
                ST_EXEC: begin
                    if (i_word_valid) begin
                        o_squash <= !pass_r;
                        if (i_word_two || words_r == 2'h1) begin
                            o_busy <= 1'b0;
                            st_r <= ST_IDLE;
                        end else begin
                            words_r <= words_r - 2'h1;
                        end
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    o_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // cfc_flow_ctrl

// ===== include/cfc_defines.vh
/*
 * Constants for the conditional flow control block: condition field
 * layout, group codes, instruction kinds, cycle counts.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CFC_DEFINES_VH
`define CFC_DEFINES_VH

// Condition operand: [3:0] group one, [5:4] group two, [7:6] group three,
// [9:8] group four; code zero in a field means the group is not tested
`define CFC_COND_W 10
`define CFC_G1_LSB 0
`define CFC_G2_LSB 4
`define CFC_G3_LSB 6
`define CFC_G4_LSB 8

// Group one codes
`define CFC_G1_NONE 4'h0
`define CFC_G1_ZERO 4'h1
`define CFC_G1_NONZERO 4'h2
`define CFC_G1_NEG 4'h3
`define CFC_G1_NONPOS 4'h4
`define CFC_G1_POS 4'h5
`define CFC_G1_NONNEG 4'h6

// Group two to four codes
`define CFC_G2_NONE 2'h0
`define CFC_G2_WRAP_SET 2'h1
`define CFC_G2_WRAP_CLR 2'h2
`define CFC_G3_NONE 2'h0
`define CFC_G3_CARRY_SET 2'h1
`define CFC_G3_CARRY_CLR 2'h2
`define CFC_G4_NONE 2'h0
`define CFC_G4_TEST_SET 2'h1
`define CFC_G4_TEST_CLR 2'h2
`define CFC_G4_PIN_LOW 2'h3

// Instruction kinds
`define CFC_OP_W 3
`define CFC_OP_NONE 3'h0
`define CFC_OP_JUMP 3'h1
`define CFC_OP_ENTRY 3'h2
`define CFC_OP_EXIT 3'h3
`define CFC_OP_EXEC1 3'h4
`define CFC_OP_EXEC2 3'h5

// Cycle counts and slot word count
`define CFC_TAKEN_CYC 4
`define CFC_UNTAKEN_CYC 2
`define CFC_DELAY_CYC 2
`define CFC_SLOT_WORDS 2'h2

`endif

// ===== design/cfc_cond_eval.v
/*
 * Combined condition evaluator: decodes up to four group fields and
 * ANDs every tested condition.
 * Assumes status inputs are already synchronous to the core clock.
 */
`timescale 1ns/100ps
`include "cfc_defines.vh"

module cfc_cond_eval #(
    parameter ACC_W = 32
) (
    input wire [`CFC_COND_W-1:0] i_cond,
    input wire [ACC_W-1:0] i_sum,
    input wire i_wrap,
    input wire i_carry,
    input wire i_test,
    input wire i_pin_sync,
    output reg o_true,
    output wire o_bad
);
    wire [3:0] g1;
    wire [1:0] g2;
    wire [1:0] g3;
    wire [1:0] g4;
    wire zero;
    wire neg;
    reg t1;
    reg t2;
    reg t3;
    reg t4;

    assign g1 = i_cond[`CFC_G1_LSB +: 4];
    assign g2 = i_cond[`CFC_G2_LSB +: 2];
    assign g3 = i_cond[`CFC_G3_LSB +: 2];
    assign g4 = i_cond[`CFC_G4_LSB +: 2];
    assign zero = (i_sum == {ACC_W{1'b0}});
    assign neg = i_sum[ACC_W-1];
    // One field per group, so two tests of one group cannot be encoded
    assign o_bad = (g1 > `CFC_G1_NONNEG) || (g2 == 2'h3) || (g3 == 2'h3);

    always @* begin
        case (g1)
            `CFC_G1_ZERO: t1 = zero;
            `CFC_G1_NONZERO: t1 = !zero;
            `CFC_G1_NEG: t1 = neg;
            `CFC_G1_NONPOS: t1 = neg || zero;
            `CFC_G1_POS: t1 = !neg && !zero;
            `CFC_G1_NONNEG: t1 = !neg;
            default: t1 = 1'b1;
        endcase
        case (g2)
            `CFC_G2_WRAP_SET: t2 = i_wrap;
            `CFC_G2_WRAP_CLR: t2 = !i_wrap;
            default: t2 = 1'b1;
        endcase
        case (g3)
            `CFC_G3_CARRY_SET: t3 = i_carry;
            `CFC_G3_CARRY_CLR: t3 = !i_carry;
            default: t3 = 1'b1;
        endcase
        case (g4)
            `CFC_G4_TEST_SET: t4 = i_test;
            `CFC_G4_TEST_CLR: t4 = !i_test;
            `CFC_G4_PIN_LOW: t4 = !i_pin_sync;
            default: t4 = 1'b1;
        endcase
        o_true = t1 && t2 && t3 && t4;
    end
endmodule // cfc_cond_eval

// ===== bench/cfc_flow_asserts.sv
/* Checker for the conditional flow control block: ties each output pulse
   to the request that was accepted. Assumes a bind onto cfc_flow_ctrl. */
`timescale 1ns/100ps
`include "cfc_defines.vh"
module cfc_flow_asserts #(
    parameter ACC_W = 32,
    parameter PC_W = 16
) (
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_issue,
    input wire [`CFC_OP_W-1:0] i_op,
    input wire i_delayed,
    input wire [`CFC_COND_W-1:0] i_cond,
    input wire [PC_W-1:0] i_target,
    input wire [PC_W-1:0] i_next_pc,
    input wire [PC_W-1:0] i_stack_top,
    input wire o_busy,
    input wire o_load_pc,
    input wire [PC_W-1:0] o_new_pc,
    input wire o_flush,
    input wire o_push,
    input wire [PC_W-1:0] o_push_pc,
    input wire o_pop,
    input wire o_squash,
    input wire o_cond_err
);
    wire take = i_issue && !o_busy && i_op != `CFC_OP_NONE && i_op <= `CFC_OP_EXEC2;
    wire take_plain = take && !i_delayed && i_op <= `CFC_OP_EXIT;
    reg [`CFC_OP_W-1:0] sop_r;
    reg sdly_r;
    reg [`CFC_COND_W-1:0] scond_r;
    reg [PC_W-1:0] stgt_r;
    reg [PC_W-1:0] snext_r;
    // Accepted request, held until the next one
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {sop_r, sdly_r, scond_r, stgt_r, snext_r} <= '0;
        end else if (take) begin
            {sop_r, sdly_r, scond_r, stgt_r, snext_r} <=
                {i_op, i_delayed, i_cond, i_target, i_next_pc};
        end
    end
    default clocking cfc_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    a_busy_after_take: assert property (take |=> o_busy)
        else $error("busy not raised after an accepted request");
    a_plain_done_time: assert property (take_plain |=> o_busy ##1 ((!o_busy && !o_load_pc)
        or (o_busy[*2] ##1 (!o_busy && o_load_pc))))
        else $error("plain transfer did not end in two or four cycles");
    a_flush_needs_load: assert property (o_flush |-> o_load_pc)
        else $error("flush without a program counter load");
    a_flush_if_plain: assert property (o_load_pc |-> o_flush == !sdly_r)
        else $error("flush does not match the transfer form");
    a_push_pc_next: assert property (o_push |-> o_load_pc && sop_r == `CFC_OP_ENTRY
        && o_push_pc == snext_r)
        else $error("push without entry or with a wrong address");
    a_pop_top_pc: assert property (o_pop |-> o_load_pc && sop_r == `CFC_OP_EXIT
        && o_new_pc == i_stack_top)
        else $error("pop without exit or with a wrong address");
    a_load_target_pc: assert property (o_load_pc && sop_r != `CFC_OP_EXIT
        |-> o_new_pc == stgt_r)
        else $error("loaded address is not the target");
    a_squash_exec_only: assert property (o_squash |-> sop_r >= `CFC_OP_EXEC1)
        else $error("squash outside conditional execute");
    a_err_bad_code: assert property (o_cond_err |-> scond_r[3:0] > 4'h6
        || scond_r[5:4] == 2'h3 || scond_r[7:6] == 2'h3)
        else $error("condition error on a legal code");
    c_plain: cover property (take_plain);
    c_delayed_load: cover property (o_load_pc && sdly_r);
    c_squash: cover property (o_squash);
    c_err: cover property (o_cond_err);
endmodule // cfc_flow_asserts

bind cfc_flow_ctrl cfc_flow_asserts #(.ACC_W(ACC_W), .PC_W(PC_W)) u_cfc_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_issue(i_issue), .i_op(i_op),
    .i_delayed(i_delayed), .i_cond(i_cond), .i_target(i_target), .i_next_pc(i_next_pc),
    .i_stack_top(i_stack_top), .o_busy(o_busy), .o_load_pc(o_load_pc),
    .o_new_pc(o_new_pc), .o_flush(o_flush), .o_push(o_push), .o_push_pc(o_push_pc),
    .o_pop(o_pop), .o_squash(o_squash), .o_cond_err(o_cond_err)
);

// ===== bench/tb.sv
/* Self-checking bench for cfc_flow_ctrl: a table of requests, then hand cases.
   Assumes default parameters and the checker bound onto the design. */
`timescale 1ns/100ps
`include "cfc_defines.vh"
module tb;
    typedef struct packed {
        logic [2:0] op;
        logic d;
        logic [1:0] nw;
        logic tw;
        logic [9:0] cd;
        logic [7:0] sm;
        logic [3:0] fl;
        logic e;
    } cfc_row_t;
    localparam logic [15:0] TGT = 16'h0ABC;
    localparam logic [15:0] NXT = 16'h0123;
    localparam logic [15:0] STK = 16'h0456;
    localparam cfc_row_t HAND_OLD = {3'h4, 4'h2, 10'h001, 8'h00, 5'h03};
    localparam cfc_row_t HAND_IRQ = {3'h4, 4'h2, 10'h001, 8'h00, 5'h02};
    // Op, {delayed, words, two-word}, condition, sum, {wrap, carry, test, pin, expect}
    cfc_row_t rows [0:24] = '{
        {3'h4, 4'h2, 10'h001, 8'h00, 5'h03}, {3'h4, 4'h2, 10'h002, 8'h00, 5'h02},
        {3'h4, 4'h2, 10'h003, 8'hFB, 5'h03}, {3'h4, 4'h2, 10'h004, 8'h07, 5'h02},
        {3'h4, 4'h2, 10'h005, 8'h07, 5'h03}, {3'h4, 4'h2, 10'h006, 8'hFB, 5'h02},
        {3'h4, 4'h2, 10'h010, 8'h00, 5'h13}, {3'h4, 4'h2, 10'h020, 8'h00, 5'h12},
        {3'h4, 4'h2, 10'h040, 8'h00, 5'h02}, {3'h4, 4'h2, 10'h080, 8'h00, 5'h03},
        {3'h4, 4'h2, 10'h100, 8'h00, 5'h07}, {3'h4, 4'h2, 10'h200, 8'h00, 5'h06},
        {3'h4, 4'h2, 10'h300, 8'h00, 5'h01}, {3'h5, 4'h4, 10'h123, 8'hFB, 5'h07},
        {3'h5, 4'h4, 10'h123, 8'hFB, 5'h02}, {3'h5, 4'h3, 10'h041, 8'h00, 5'h02},
        {3'h4, 4'h2, 10'h00F, 8'h00, 5'h02}, {3'h1, 4'h0, 10'h001, 8'h00, 5'h03},
        {3'h1, 4'h0, 10'h002, 8'h00, 5'h02}, {3'h2, 4'h0, 10'h005, 8'h07, 5'h03},
        {3'h3, 4'h0, 10'h010, 8'h00, 5'h13}, {3'h3, 4'h0, 10'h020, 8'h00, 5'h12},
        {3'h1, 4'hB, 10'h001, 8'h00, 5'h03}, {3'h2, 4'hC, 10'h001, 8'h00, 5'h03},
        {3'h3, 4'hC, 10'h002, 8'h00, 5'h02}};
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_issue = 1'h0;
    logic [2:0] i_op = 3'h0;
    logic i_delayed = 1'h0;
    logic [9:0] i_cond = 10'h000;
    logic i_word_two = 1'h0;
    logic i_word_valid = 1'h0;
    logic i_after_irq = 1'h0;
    logic [31:0] i_sum = 32'h0;
    logic i_wrap = 1'h0;
    logic i_carry = 1'h0;
    logic i_test = 1'h0;
    logic i_pin = 1'h1;
    wire o_busy, o_load_pc, o_flush, o_push, o_pop, o_squash, o_cond_err;
    wire [15:0] o_new_pc, o_push_pc;
    int err_total = 0;
    int n_tests = 0;
    int i;
    cfc_flow_ctrl dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_issue(i_issue), .i_op(i_op),
        .i_delayed(i_delayed), .i_cond(i_cond), .i_target(TGT), .i_next_pc(NXT),
        .i_word_two(i_word_two), .i_word_valid(i_word_valid), .i_after_irq(i_after_irq),
        .i_sum(i_sum), .i_wrap(i_wrap), .i_carry(i_carry), .i_test(i_test), .i_pin(i_pin),
        .i_stack_top(STK), .o_busy(o_busy), .o_load_pc(o_load_pc), .o_new_pc(o_new_pc),
        .o_flush(o_flush), .o_push(o_push), .o_push_pc(o_push_pc), .o_pop(o_pop),
        .o_squash(o_squash), .o_cond_err(o_cond_err));
    always #4 i_mclk = ~i_mclk;
    task automatic close_out;
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Sets status, issues one request, feeds its words and tallies the pulses
    task automatic op(input cfc_row_t r, input logic [7:0] ls, input logic irq);
        int k;
        int cyc;
        logic [3:0] ld, fl, pu, po, sq, er;
        logic tr;
        {ld, fl, pu, po, sq, er} = 24'h0;
        cyc = 0;
        tr = r.op <= `CFC_OP_EXIT;
        @(posedge i_mclk);
        i_sum <= {{24{r.sm[7]}}, r.sm};
        {i_wrap, i_carry, i_test, i_pin} <= r.fl;
        repeat (3) @(posedge i_mclk);
        i_sum <= {{24{ls[7]}}, ls};
        i_issue <= 1'h1;
        i_op <= r.op;
        i_delayed <= r.d;
        i_cond <= r.cd;
        i_after_irq <= irq;
        for (k = 0; k < 12; k++) begin
            @(posedge i_mclk);
            i_issue <= 1'h0;
            i_word_valid <= k < r.nw;
            i_word_two <= k == 0 && r.tw;
            if (k == 0 && r.d) i_sum <= ~i_sum;
            #1;
            {ld, fl, pu, po} = {ld + o_load_pc, fl + o_flush, pu + o_push, po + o_pop};
            {sq, er} = {sq + o_squash, er + o_cond_err};
            if (o_busy === 1'h0 && cyc == 0) cyc = k;
        end
        chk(ld, tr && r.e);
        chk(fl, tr && r.e && !r.d);
        chk(pu, r.op == `CFC_OP_ENTRY && r.e);
        chk(po, r.op == `CFC_OP_EXIT && r.e);
        chk(sq, (!tr && !r.e) ? r.nw : 2'h0);
        chk(er, r.cd[3:0] > 4'h6);
        if (tr && !r.d) chk(cyc, r.e ? `CFC_TAKEN_CYC - 1 : `CFC_UNTAKEN_CYC - 1);
        if (tr && r.e) chk(o_new_pc, r.op == `CFC_OP_EXIT ? STK : TGT);
        if (r.op == `CFC_OP_ENTRY && r.e) chk(o_push_pc, NXT);
        if (o_busy !== 1'h0) begin
            chk(o_busy, 1'h0);
            close_out();
        end
    endtask
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        @(posedge i_mclk);
        #1;
        chk({o_busy, o_load_pc, o_flush, o_push, o_pop, o_squash, o_cond_err}, 7'h00);
        for (i = 0; i < 25; i++) op(rows[i], rows[i].sm, 1'h0);
        op(HAND_OLD, 8'h07, 1'h0);
        op(HAND_IRQ, 8'h07, 1'h1);
        // Reset in the middle of a taken jump: no late load, clean restart
        @(posedge i_mclk);
        i_sum <= 32'h0;
        i_cond <= 10'h001;
        i_op <= `CFC_OP_JUMP;
        i_delayed <= 1'h0;
        i_issue <= 1'h1;
        @(posedge i_mclk);
        i_issue <= 1'h0;
        @(posedge i_mclk);
        i_rst_n <= 1'h0;
        for (i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            if (i == 3) i_rst_n <= 1'h1;
            #1;
            chk({o_busy, o_load_pc, o_flush, o_push, o_pop}, 5'h00);
        end
        op(rows[17], rows[17].sm, 1'h0);
        close_out();
    end
endmodule // tb
